//--- motor_pkg.sv
// Shared constants and types of the motor speed control block.
// Assumes a single 20 MHz clock and an APB master with 32-bit data.
`default_nettype none
package motor_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 20_000_000;      // System clock
  localparam int unsigned BLANK_US   = 3;               // Current sense blanking
  localparam int unsigned BLANK_CYC  = (BLANK_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned PWM_HZ     = 37_000;          // Carrier, 15..50 kHz
  localparam int unsigned PWM_PER    = CLK_HZ / PWM_HZ; // Cycles per carrier
  localparam int unsigned MASK_MS    = 90;              // Lock mask time
  localparam int unsigned MASK_CYC   = MASK_MS * (CLK_HZ / 1000);
  localparam int unsigned PROT_S     = 8;               // Stall protection time
  localparam int unsigned PROT_CYC   = PROT_S * CLK_HZ;
  localparam int unsigned TOL_US     = 100;             // Lock phase tolerance
  localparam int unsigned TOL_CYC    = TOL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LOSS_FG    = 16;              // Feedback edges without clock
  localparam logic [9:0]  DUTY_STEP  = 10'h004;         // Duty change per clock edge
  localparam logic [9:0]  DUTY_MAX   = 10'(PWM_PER);    // Full on
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS   = 8'h00;           // Start, brake, protect enable
  localparam logic [7:0]  STAT_OFS   = 8'h04;           // Sticky events, W1C
  localparam logic [7:0]  MASK_OFS   = 8'h08;           // Interrupt mask
  localparam logic [7:0]  STATE_OFS  = 8'h0C;           // Live state, read only
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_BRAKE = 1;
  localparam int unsigned CTRL_PROT  = 2;
  localparam logic [2:0]  CTRL_RST   = 3'h4;
  localparam int unsigned EV_LOCK    = 0;               // Indicator went low
  localparam int unsigned EV_UNLOCK  = 1;               // Indicator went high
  localparam int unsigned EV_ILIM    = 2;               // Current limit cut
  localparam int unsigned EV_PROT    = 3;               // Protection tripped
  localparam logic [3:0]  EV_RST     = 4'h0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STOP    = 2'b00,
    ST_START   = 2'b01,
    ST_BRAKE   = 2'b10,
    ST_PROTECT = 2'b11
  } state_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
endpackage
`default_nettype wire

//--- motor_pll_speed_control.sv
// Speed loop, PWM drive, current limit, lock indicator and protection.
// Pins come from outside the clock domain and are synchronised here.
// Function
// - Select low hides short unlock pulses
// - Select high hides short lock pulses
// - Undriven select pins read as high
// - Brake reverse on low, coast on high
// - Compare falling edges of clock, feedback
// - Adjust duty until feedback equals clock
// - Power set by low-side on-duty
// - Cut on-duty at sense threshold
// - Ignore sense during turn-on blanking
// - Stopped state enters power saving
// - Regulator stays on in power saving
// - No clock, protection on: drive off
// - Carrier between 15 and 50 kHz
// - Mask hides pulses shorter than mask time
// - Unlocked for protect time: outputs off
`default_nettype none
module motor_pll_speed_control #(
  parameter int unsigned MASK_CYCLES = motor_pkg::MASK_CYC,
  parameter int unsigned PROT_CYCLES = motor_pkg::PROT_CYC
) (
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  input  wire motor_pkg::apb_req_t i_apb,
  output var  motor_pkg::apb_rsp_t o_apb,
  input  wire logic                i_ref_clk,
  input  wire logic                i_feedback_input_pos,
  input  wire logic                i_lock_mask_select,
  input  wire logic                i_lock_mask_select_drv,
  input  wire logic                i_brake_select,
  input  wire logic                i_brake_select_drv,
  input  wire logic                i_sense_over,
  output logic                     o_lowside_on,
  output logic                     o_reverse_torque,
  output logic                     o_lock_indicator,
  output logic                     o_shaped_feedback_output,
  output logic                     o_power_save,
  output logic                     o_regulator_on,
  output logic                     o_irq
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] meta_q;   // First stage, read only by second
  logic [6:0] sync_q;   // Second stage
  logic [1:0] prev_q;   // Delayed clock and feedback for edges
  always_ff @(posedge i_clk) begin
    meta_q <= {i_sense_over, i_brake_select_drv, i_brake_select,
               i_lock_mask_select_drv, i_lock_mask_select,
               i_feedback_input_pos, i_ref_clk};
    sync_q <= meta_q;
    prev_q <= sync_q[1:0];
  end
  logic ref_fall, fb_fall, mask_sel, brake_sel, sense_over;
  assign ref_fall   = prev_q[0] & ~sync_q[0];
  assign fb_fall    = prev_q[1] & ~sync_q[1];
  assign mask_sel   = sync_q[3] ? sync_q[2] : 1'b1;
  assign brake_sel  = sync_q[5] ? sync_q[4] : 1'b1;
  assign sense_over = sync_q[6];

  // ----------------------------------------------------------------
  // Register file over APB
  // ----------------------------------------------------------------
  logic [2:0]        ctrl_q;    // Start, brake, protection enable
  logic [3:0]        stat_q;    // Sticky events
  logic [3:0]        mask_q;    // Interrupt enables
  logic [3:0]        ev;        // Event pulses this cycle
  motor_pkg::state_t state_q;
  logic [9:0]        duty_q;
  logic              wr_en, rd_en;
  assign wr_en = i_apb.psel & i_apb.penable & o_apb.pready & i_apb.pwrite;
  assign rd_en = i_apb.psel & ~i_apb.penable;

  // Ready in the first access cycle, read data captured at setup
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_apb <= '0;
    end else begin
      o_apb.pready  <= rd_en;
      o_apb.pslverr <= 1'b0;
      o_apb.prdata  <= 32'h0000_0000;
      if (rd_en) begin
        if (i_apb.paddr == motor_pkg::CTRL_OFS) begin
          o_apb.prdata <= {29'h0, ctrl_q};
        end else if (i_apb.paddr == motor_pkg::STAT_OFS) begin
          o_apb.prdata <= {28'h0, stat_q};
        end else if (i_apb.paddr == motor_pkg::MASK_OFS) begin
          o_apb.prdata <= {28'h0, mask_q};
        end else if (i_apb.paddr == motor_pkg::STATE_OFS) begin
          o_apb.prdata <= {19'h0, o_lock_indicator, state_q, duty_q};
        end else begin
          o_apb.pslverr <= 1'b1;
        end
      end
    end
  end

  // Control and mask writes
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= motor_pkg::CTRL_RST;
      mask_q <= motor_pkg::EV_RST;
    end else if (wr_en) begin
      if (i_apb.paddr == motor_pkg::CTRL_OFS) begin
        ctrl_q <= i_apb.pwdata[2:0];
      end else if (i_apb.paddr == motor_pkg::MASK_OFS) begin
        mask_q <= i_apb.pwdata[3:0];
      end
    end
  end

  // Sticky status, a new event wins over a clearing write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      stat_q <= motor_pkg::EV_RST;
    end else if (wr_en && i_apb.paddr == motor_pkg::STAT_OFS) begin
      stat_q <= (stat_q & ~i_apb.pwdata[3:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  // Interrupt level
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) o_irq <= 1'b0;
    else           o_irq <= |(stat_q & mask_q);
  end

  // ----------------------------------------------------------------
  // Phase comparator and lock detection
  // ----------------------------------------------------------------
  logic [1:0]  fb_cnt_q;    // Feedback edges since last clock edge
  logic [4:0]  loss_q;      // Feedback edges with no clock edge
  logic [31:0] since_fb_q;  // Cycles since last feedback edge
  logic        unlock_raw_q;
  logic        running;
  assign running = (state_q == motor_pkg::ST_START);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fb_cnt_q     <= 2'h0;
      loss_q       <= 5'h00;
      since_fb_q   <= 32'h0000_0000;
      unlock_raw_q <= 1'b1;
    end else begin
      since_fb_q <= fb_fall ? 32'h0000_0000 : since_fb_q + 32'h0000_0001;
      if (ref_fall) begin
        fb_cnt_q <= 2'h0;
        loss_q   <= 5'h00;
        // one feedback edge, leading the clock edge within tolerance
        unlock_raw_q <= ~(running && fb_cnt_q == 2'h1 && since_fb_q < motor_pkg::TOL_CYC);
      end else begin
        if (fb_fall && fb_cnt_q != 2'h3) fb_cnt_q <= fb_cnt_q + 2'h1;
        if (fb_fall && loss_q != 5'h1F) loss_q <= loss_q + 5'h01;
        if (!running) unlock_raw_q <= 1'b1;
      end
    end
  end

  // raise duty when slow, lower when fast
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || state_q == motor_pkg::ST_STOP) begin
      duty_q <= 10'h000;
    end else if (ref_fall && fb_cnt_q == 2'h0 && duty_q <= motor_pkg::DUTY_MAX - motor_pkg::DUTY_STEP) begin
      duty_q <= duty_q + motor_pkg::DUTY_STEP;
    end else if (ref_fall && fb_cnt_q >= 2'h2 && duty_q >= motor_pkg::DUTY_STEP) begin
      duty_q <= duty_q - motor_pkg::DUTY_STEP;
    end
  end

  // ----------------------------------------------------------------
  // Lock indicator masking
  // ----------------------------------------------------------------
  logic [31:0] mcnt_q;
  logic        masked_dir;
  // delay rising edge when select low; falling edge when high
  assign masked_dir = mask_sel ? ~unlock_raw_q : unlock_raw_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_lock_indicator <= 1'b1;
      mcnt_q           <= 32'h0000_0000;
    end else if (unlock_raw_q == o_lock_indicator) begin
      mcnt_q <= 32'h0000_0000;
    end else if (!masked_dir || mcnt_q >= MASK_CYCLES - 1) begin
      // change at once in the unmasked direction, else once the mask time has passed
      o_lock_indicator <= unlock_raw_q;
      mcnt_q           <= 32'h0000_0000;
    end else begin
      mcnt_q <= mcnt_q + 32'h0000_0001;
    end
  end
  logic lk_prev_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) lk_prev_q <= 1'b1;
    else           lk_prev_q <= o_lock_indicator;
  end

  // ----------------------------------------------------------------
  // State and protection
  // ----------------------------------------------------------------
  logic [31:0] prot_q;   // Cycles unlocked while starting
  logic        trip;
  // unlocked too long; feedback turning with no clock
  assign trip = running && ctrl_q[motor_pkg::CTRL_PROT] &&
                (prot_q >= PROT_CYCLES - 1 || loss_q >= motor_pkg::LOSS_FG);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !running || !o_lock_indicator) prot_q <= 32'h0000_0000;
    else                                           prot_q <= prot_q + 32'h0000_0001;
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !ctrl_q[motor_pkg::CTRL_START]) begin
      state_q <= motor_pkg::ST_STOP;
    end else begin
      case (state_q)
        motor_pkg::ST_STOP:    state_q <= motor_pkg::ST_START;
        motor_pkg::ST_START: begin
          if (trip)                                 state_q <= motor_pkg::ST_PROTECT;
          else if (ctrl_q[motor_pkg::CTRL_BRAKE]) state_q <= motor_pkg::ST_BRAKE;
        end
        motor_pkg::ST_BRAKE: begin
          if (!ctrl_q[motor_pkg::CTRL_BRAKE]) state_q <= motor_pkg::ST_START;
        end
        default:               state_q <= motor_pkg::ST_PROTECT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // PWM carrier, blanking and current limit
  // ----------------------------------------------------------------
  logic [9:0] pwm_q;    // Carrier phase
  logic [6:0] blank_q;  // Cycles since turn-on
  logic       cut_q;    // On-duty cut for rest of period
  logic       drive;
  // reverse torque on low select, coast on high
  assign drive = running || (state_q == motor_pkg::ST_BRAKE && !brake_sel);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pwm_q   <= 10'h000;
      blank_q <= 7'h00;
      cut_q   <= 1'b0;
    end else begin
      // fixed carrier inside the allowed band
      pwm_q   <= (pwm_q == motor_pkg::DUTY_MAX - 10'h001) ? 10'h000 : pwm_q + 10'h001;
      blank_q <= o_lowside_on ? ((blank_q == 7'h7F) ? blank_q : blank_q + 7'h01) : 7'h00;
      if (pwm_q == motor_pkg::DUTY_MAX - 10'h001) begin
        cut_q <= 1'b0;
      // sense ignored in blanking; cut on over-current
      end else if (o_lowside_on && blank_q >= 7'(motor_pkg::BLANK_CYC) && sense_over) begin
        cut_q <= 1'b1;
      end
    end
  end

  // Drive outputs
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_lowside_on             <= 1'b0;
      o_reverse_torque         <= 1'b0;
      o_power_save             <= 1'b1;
      o_regulator_on           <= 1'b1;
      o_shaped_feedback_output <= 1'b0;
    end else begin
      o_lowside_on             <= drive && pwm_q < duty_q && !cut_q;
      o_reverse_torque         <= state_q == motor_pkg::ST_BRAKE && !brake_sel;
      // stop state saves power; regulator kept on
      o_power_save             <= state_q == motor_pkg::ST_STOP;
      o_regulator_on           <= 1'b1;
      o_shaped_feedback_output <= sync_q[1];
    end
  end

  // Events for status
  assign ev[motor_pkg::EV_LOCK]   = lk_prev_q & ~o_lock_indicator;
  assign ev[motor_pkg::EV_UNLOCK] = ~lk_prev_q & o_lock_indicator;
  assign ev[motor_pkg::EV_ILIM]   = o_lowside_on & blank_q >= 7'(motor_pkg::BLANK_CYC) & sense_over;
  assign ev[motor_pkg::EV_PROT]   = trip;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  unmask_hold_a: assert property (!mask_sel && !o_lock_indicator && unlock_raw_q ##1 !unlock_raw_q
                                  |=> !o_lock_indicator)
    else $error("short unlock pulse leaked");
  lock_mask_a: assert property (mask_sel && o_lock_indicator && !unlock_raw_q ##1 unlock_raw_q
                                |=> o_lock_indicator)
    else $error("short lock pulse leaked");
  open_select_a: assert property (!sync_q[5] && state_q == motor_pkg::ST_BRAKE
                                  |=> !o_reverse_torque)
    else $error("undriven brake select not high");
  brake_mode_a: assert property (state_q == motor_pkg::ST_BRAKE && brake_sel |=> !o_lowside_on)
    else $error("coast mode drives");
  duty_rise_a: assert property (running && ref_fall && fb_cnt_q == 2'h0 && duty_q < 10'h100
                                |=> duty_q == $past(duty_q) + motor_pkg::DUTY_STEP)
    else $error("duty not raised when slow");
  blank_ignore_a: assert property (o_lowside_on && blank_q < 7'(motor_pkg::BLANK_CYC)
                                   && pwm_q != motor_pkg::DUTY_MAX - 10'h001 |=> !cut_q || $past(cut_q))
    else $error("limit inside blanking");
  limit_cut_a: assert property (cut_q |=> !o_lowside_on || pwm_q == 10'h000)
    else $error("drive during current cut");
  stop_save_a: assert property (state_q == motor_pkg::ST_STOP |=> o_power_save && o_regulator_on)
    else $error("stop without power save");
  protect_off_a: assert property (state_q == motor_pkg::ST_PROTECT |=> !o_lowside_on [*2])
    else $error("drive in protection");
  unlocked_stop_a: assert property (!running ##1 !running |-> unlock_raw_q)
    else $error("locked while not running");
  irq_level_a: assert property (|(stat_q & mask_q) |=> o_irq)
    else $error("interrupt not raised");
  cv_lock: cover property (lk_prev_q && !o_lock_indicator);
  cv_trip: cover property (trip);
  cv_cut: cover property (cut_q && running);
  cv_rev: cover property (o_reverse_torque);
endmodule
`default_nettype wire

//--- motor_model.sv
// Stand-in for the host and the motor: reference clock and feedback pulses.
// Assumes the bench clock; the feedback mode is taken once per period.
`default_nettype none
module motor_model #(
  parameter int PER = 2000           // Reference period in clocks
) (
  input  wire logic       i_clk,
  input  wire logic       i_ref_on,
  input  wire logic [1:0] i_fb_mode,
  output logic            o_ref_clk,
  output logic            o_feedback
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Period counter and pins
  // ------------------------------------------------------------
  int         cnt  = 0;              // Position within the period
  logic [1:0] mode = 2'h0;           // 0 none, 1 one edge, 2 two edges
  // Stopped clock stays high; feedback edge lands 200 clocks before it
  // period kept long
  always @(posedge i_clk) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    if (cnt == 0) begin
      mode <= i_fb_mode;
    end
    o_ref_clk  <= !i_ref_on || cnt < PER / 2;
    o_feedback <= !((mode != 2'h0 && cnt >= PER / 2 - 200 && cnt < PER / 2 - 100) ||
                    (mode == 2'h2 && cnt >= 100 && cnt < 200));
  end
endmodule
`default_nettype wire

//--- motor_pll_speed_control_tb.sv
// Self-checking bench of the motor speed control block.
// Assumes motor_model drives the reference clock and feedback pins.
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module motor_pll_speed_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int MASK_T = 5000;              // Shortened mask time
  localparam int PROT_T = 3000;              // Shortened protection time
  localparam int PER    = 2000;              // Reference period, 10 kHz
  localparam int LIMIT  = 95000;             // Cycle ceiling of the run
  logic                clk     = 1'b0;       // System clock
  logic                rst     = 1'b1;       // Synchronous reset
  motor_pkg::apb_req_t req     = '0;         // APB request
  motor_pkg::apb_rsp_t rsp;                  // APB response
  logic                ref_on  = 1'b1;       // Reference clock running
  logic [1:0]          fb_mode = 2'h0;       // Feedback edges per period
  logic                sel_lvl = 1'b0;       // Lock mask select level
  logic                sel_drv = 1'b0;       // Lock mask select driven
  logic                brk_lvl = 1'b0;       // Brake select level
  logic                brk_drv = 1'b0;       // Brake select driven
  logic                sense   = 1'b0;       // Sense over threshold
  logic                watch   = 1'b0;       // Window watch active
  logic                keep    = 1'b1;       // Indicator level expected
  logic                ref_clk, fb, lowside, reverse, ind, psave, reg_on, irq;
  logic                fbs;                  // Shaped feedback output
  logic [2:0]          fb_dly;               // Feedback pin, three cycles back
  logic                seen_on, seen_ind;    // Sticky watch flags
  logic                seen_fbs;             // Shaped feedback mismatch seen
  logic [31:0]         rd;                   // Last read data
  logic                err;                  // Last error response
  logic [9:0]          d0;                   // Saved duty
  int                  n_mismatch = 0;
  int                  n_checks   = 0;
  int                  cyc        = 0;
  int                  hi, per;
  always #25 clk = ~clk;
  motor_pll_speed_control #(.MASK_CYCLES(MASK_T), .PROT_CYCLES(PROT_T)) dut_u (
    .i_clk(clk), .i_sys_rst(rst), .i_apb(req), .o_apb(rsp), .i_ref_clk(ref_clk),
    .i_feedback_input_pos(fb), .i_lock_mask_select(sel_lvl), .i_lock_mask_select_drv(sel_drv),
    .i_brake_select(brk_lvl), .i_brake_select_drv(brk_drv), .i_sense_over(sense),
    .o_lowside_on(lowside), .o_reverse_torque(reverse), .o_lock_indicator(ind),
    .o_shaped_feedback_output(fbs), .o_power_save(psave), .o_regulator_on(reg_on), .o_irq(irq));
  motor_model #(.PER(PER)) model_u (
    .i_clk(clk), .i_ref_on(ref_on), .i_fb_mode(fb_mode), .o_ref_clk(ref_clk), .o_feedback(fb));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Watch windows and the run timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    fb_dly <= {fb_dly[1:0], fb};
    if (!watch) begin
      seen_on  <= 1'b0;
      seen_ind <= 1'b0;
      seen_fbs <= 1'b0;
    end else begin
      if (lowside !== 1'b0) seen_on <= 1'b1;
      if (ind !== keep) seen_ind <= 1'b1;
      // Two synchroniser stages and the output flop
      if (fbs !== fb_dly[2]) seen_fbs <= 1'b1;
    end
    if (cyc == LIMIT) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // Sample pready at each rising edge; only the run timeout ends a hang
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  // Watch for n cycles: no drive, indicator steady at k
  task automatic hold(input int n, input logic k);
    @(posedge clk);
    keep  <= k;
    watch <= 1'b1;
    repeat (n) @(posedge clk);
    watch <= 1'b0;
    @(posedge clk);
  endtask
  // On time and period of one carrier cycle
  task automatic pwm_meas(output int h, output int p);
    logic s [0:1199];
    int   i, r1, r2;
    for (i = 0; i < 1200; i++) begin
      @(posedge clk);
      s[i] = lowside;
    end
    r1 = -1;
    r2 = -1;
    h  = 0;
    for (i = 1; i < 1200; i++) if (s[i] === 1'b1 && s[i-1] === 1'b0) begin
      if (r1 < 0) r1 = i;
      else if (r2 < 0) r2 = i;
    end
    for (i = r1; i >= 0 && i < 1200 && s[i] === 1'b1; i++) h++;
    p = r2 - r1;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    `CHK("power save", 1'b1, psave)
    `CHK("regulator", 1'b1, reg_on)
    `CHK("indicator", 1'b1, ind)
    apb(1'b0, motor_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl reset", 32'(motor_pkg::CTRL_RST), rd)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    $display("test reset done");
    apb(1'b1, motor_pkg::MASK_OFS, 32'h1);
    apb(1'b1, motor_pkg::CTRL_OFS, 32'h1);
    repeat (20 * PER) @(posedge clk);
    apb(1'b0, motor_pkg::STATE_OFS, 32'h0);
    `CHK("duty rises", 1'b1, rd[9:0] >= 10'h04C && rd[9:0] <= 10'h054)
    `CHK("power save off", 1'b0, psave)
    `CHK("regulator run", 1'b1, reg_on)
    pwm_meas(hi, per);
    `CHK("on time", 1'b1, hi >= int'(rd[9:0]) - 4 && hi <= int'(rd[9:0]) + 4)
    `CHK("carrier period", int'(motor_pkg::PWM_PER), per)
    sense <= 1'b1;
    pwm_meas(hi, per);
    // Cut flop and output flop add two cycles after the blanking count
    `CHK("limited on time", int'(motor_pkg::BLANK_CYC) + 2, hi)
    sense <= 1'b0;
    apb(1'b0, motor_pkg::STAT_OFS, 32'h0);
    `CHK("limit event", 1'b1, rd[motor_pkg::EV_ILIM])
    $display("test drive done");
    fb_mode <= 2'h1;
    repeat (PER) @(posedge clk);
    fb_mode <= 2'h0;
    hold(2 * PER, 1'b1);
    `CHK("short lock hidden", 1'b0, seen_ind)
    fb_mode <= 2'h1;
    hold(2 * PER, 1'b1);
    `CHK("lock delayed", 1'b0, seen_ind)
    `CHK("shaped feedback", 1'b0, seen_fbs)
    repeat (3 * PER) @(posedge clk);
    `CHK("locked", 1'b0, ind)
    `CHK("irq lock", 1'b1, irq)
    apb(1'b1, motor_pkg::STAT_OFS, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    $display("test lock high select done");
    sel_drv <= 1'b1;
    apb(1'b0, motor_pkg::STATE_OFS, 32'h0);
    d0 = rd[9:0];
    fb_mode <= 2'h2;
    repeat (PER) @(posedge clk);
    fb_mode <= 2'h1;
    hold(2 * PER, 1'b0);
    `CHK("short unlock hidden", 1'b0, seen_ind)
    apb(1'b0, motor_pkg::STATE_OFS, 32'h0);
    `CHK("duty falls", 10'(d0 - 10'h004), rd[9:0])
    fb_mode <= 2'h0;
    hold(2 * PER, 1'b0);
    `CHK("unlock delayed", 1'b0, seen_ind)
    repeat (3 * PER) @(posedge clk);
    `CHK("unlocked", 1'b1, ind)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, motor_pkg::MASK_OFS, 32'h2);
    repeat (3) @(posedge clk);
    `CHK("irq unlock", 1'b1, irq)
    apb(1'b1, motor_pkg::STAT_OFS, 32'hF);
    $display("test lock low select done");
    brk_drv <= 1'b1;
    apb(1'b1, motor_pkg::CTRL_OFS, 32'h3);
    repeat (10) @(posedge clk);
    `CHK("reverse torque", 1'b1, reverse)
    brk_drv <= 1'b0;
    // Let the select pass its synchroniser and the output flop
    repeat (4) @(posedge clk);
    hold(600, 1'b1);
    `CHK("coast reverse", 1'b0, reverse)
    `CHK("coast drive", 1'b0, seen_on)
    $display("test brake done");
    apb(1'b1, motor_pkg::CTRL_OFS, 32'h0);
    hold(600, 1'b1);
    `CHK("stop drive", 1'b0, seen_on)
    `CHK("stop save", 1'b1, psave)
    `CHK("stop regulator", 1'b1, reg_on)
    apb(1'b0, motor_pkg::STATE_OFS, 32'h0);
    `CHK("stop state", 12'h000, rd[11:0])
    $display("test stop done");
    ref_on  <= 1'b0;
    fb_mode <= 2'h1;
    apb(1'b1, motor_pkg::CTRL_OFS, 32'h5);
    repeat (PROT_T + 1000) @(posedge clk);
    apb(1'b0, motor_pkg::STATE_OFS, 32'h0);
    `CHK("protect state", 2'h3, rd[11:10])
    hold(600, 1'b1);
    `CHK("protect drive", 1'b0, seen_on)
    apb(1'b0, motor_pkg::STAT_OFS, 32'h0);
    `CHK("protect event", 1'b1, rd[motor_pkg::EV_PROT])
    $display("test protect done");
    give_verdict();
  end
endmodule
`default_nettype wire
